// ==== verilog/pwm_timing_regs.svh ====
`ifndef PWM_TIMING_REGS_SVH
`define PWM_TIMING_REGS_SVH
`define REG_HALF_PERIOD 8'h00
`define REG_DEAD_TIME 8'h04
`define REG_MIN_PULSE 8'h08
`define REG_SYNC_WIDTH 8'h0c
`define REG_DUTY_A 8'h10
`define REG_DUTY_B 8'h14
`define REG_DUTY_C 8'h18
`define REG_MODE_CONTROL 8'h1c
`define REG_SYSTEM_STATUS 8'h20
`define REG_OUTPUT_STEERING 8'h24
`define MODE_DOUBLE_BIT 6
`define STAT_HALF_BIT 3
`define STAT_RUN_BIT 0
`define SYNC_WIDTH_RST 8'h27
`define STEERING_RST 9'h000
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11
`endif

// ==== verilog/pwm_timing_pkg.sv ====
package pwm_timing_pkg;
   typedef struct packed {
      logic [15:0] tm;
      logic [9:0] dt;
      logic [15:0] pd;
      logic [7:0] sw;
      logic [2:0][15:0] duty;
   } cfg_s;
   typedef struct packed {
      logic [2:0] hi;
      logic [2:0] lo;
   } pair_out_s;
   typedef struct packed {
      cfg_s shadow;
      cfg_s act;
      logic [8:0] steer_sh;
      logic [8:0] steer_act;
      logic double_mode;
      logic [3:0] written;
      logic run;
      logic half;
      logic [15:0] cnt;
      logic sync;
      logic [7:0] sync_left;
      logic irq;
      pair_out_s pairs;
      logic awready;
      logic wready;
      logic aw_full;
      logic w_full;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_s;
endpackage

// ==== verilog/three_phase_pwm_timing_core.sv ====
// Function
// [R1] Period value counts instruction ticks in half a switching period.
// [R2] Full switching period lasts twice the half-period count.
// [R3] Period register accepts any 16-bit value up to all ones.
// [R4] All timing counts advance once per instruction clock.
// [R5] Complement turn-on trails turn-off by dead-time count times two ticks.
// [R6] Dead-time register is 10 bits, steps of two ticks.
// [R7] Dead-time zero inserts no delay.
// [R8] Mode bit clear selects single update, set selects double update.
// [R9] Mode bit clears on reset, starting in single update.
// [R10] Single update: one sync per period, its rise latches all timing values.
// [R11] Each sync rise also latches the output steering register.
// [R12] Double update: extra midpoint sync latches everything again.
// [R13] Half-cycle status bit is zero in first half, one in second.
// [R14] Sync pulse lasts sync-width plus one ticks.
// [R15] Sync-width resets to 39, a 40-tick pulse.
// [R16] Three 16-bit duty registers, one per output pair.
// [R17] Sync pulse goes to the converter sequencer, once or twice per period.
// [R18] Duty sets high-side on-time per half period before dead time.
// [R19] Counters stay off until period and all duties were written.
// [R20] On-time below minimum pulse holds output off, complement fully on.
// [R21] An interrupt request is raised on each sync pulse.
// [R22] Up/down counter compares against duties for centred outputs.
// [R23] Sync-width register is an 8-bit field.
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "pwm_timing_regs.svh"
module three_phase_pwm_timing_core #(
   parameter int NCH = 3
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   output pwm_timing_pkg::pair_out_s PAIRS,
   output logic [8:0] STEER,
   output logic SYNC,
   output logic IRQ
);
   import pwm_timing_pkg::*;

   generate
      if (NCH != 3)
      begin : g_bad
         $error("Timing core serves exactly three output pairs.");
      end
   endgenerate

   state_s s_q;
   state_s s_d;
   logic [NCH-1:0] hi_raw;
   logic [NCH-1:0] lo_raw;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Comparisons use the registered count, so pair outputs trail SYNC by one tick.
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++)
      begin : g_pair
         logic [16:0] tm;
         logic [16:0] duty;
         logic [16:0] dt;
         logic [16:0] on_hi;
         logic [16:0] win_lo;
         logic [16:0] on_lo;
         logic hi_cmp;
         logic lo_cmp;
         assign tm = {1'b0, s_q.act.tm};
         assign duty = {1'b0, s_q.act.duty[ch]};
         assign dt = {7'h00, s_q.act.dt};
         // High on-time is the duty shortened by dead time, never negative.
         assign on_hi = (duty > dt) ? duty - dt : 17'h00000; // [R18] [R7]
         // The low window widens by dead time, so each edge moves by one dead time.
         assign win_lo = (duty + dt >= tm) ? tm : duty + dt; // [R5] [R6]
         assign on_lo = tm - win_lo;
         // Centred window: counter rises in the first half and falls in the second.
         assign hi_cmp = s_q.half ? ({1'b0, s_q.cnt} > tm - on_hi)
                                  : ({1'b0, s_q.cnt} >= tm - on_hi); // [R22]
         assign lo_cmp = s_q.half ? ({1'b0, s_q.cnt} <= tm - win_lo)
                                  : ({1'b0, s_q.cnt} < tm - win_lo); // [R22]
         always_comb
         begin
            if (!s_q.run)
            begin
               hi_raw[ch] = 1'b0; // [R19]
               lo_raw[ch] = 1'b0;
            end
            else if (on_hi < {1'b0, s_q.act.pd})
            begin
               hi_raw[ch] = 1'b0; // [R20]
               lo_raw[ch] = 1'b1;
            end
            else if (on_lo < {1'b0, s_q.act.pd})
            begin
               hi_raw[ch] = 1'b1; // [R20]
               lo_raw[ch] = 1'b0;
            end
            else
            begin
               hi_raw[ch] = hi_cmp;
               lo_raw[ch] = lo_cmp;
            end
         end
      end
   endgenerate

   always_comb
   begin
      logic start;
      logic mid;
      logic [31:0] w;
      start = 1'b0;
      mid = 1'b0;
      w = 32'h00000000;
      s_d = s_q;
      s_d.irq = 1'b0;
      s_d.pairs.hi = hi_raw;
      s_d.pairs.lo = lo_raw;

      // Write address and data are taken independently, in either order.
      if (AWVALID && s_q.awready)
      begin
         s_d.aw_full = 1'b1;
         s_d.awaddr = AWADDR;
      end
      if (WVALID && s_q.wready)
      begin
         s_d.w_full = 1'b1;
         s_d.wdata = WDATA;
         s_d.wstrb = WSTRB;
      end
      if (BREADY && s_q.bvalid)
      begin
         s_d.bvalid = 1'b0;
      end
      if (s_d.aw_full && s_d.w_full && !s_q.bvalid)
      begin
         s_d.aw_full = 1'b0;
         s_d.w_full = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = `RESP_OKAY;
         case (s_d.awaddr)
            `REG_HALF_PERIOD:
            begin
               w = merge({16'h0000, s_q.shadow.tm}, s_d.wdata, s_d.wstrb);
               s_d.shadow.tm = w[15:0]; // [R1] [R3]
               s_d.written[3] = 1'b1; // [R19]
            end
            `REG_DEAD_TIME:
            begin
               w = merge({22'h0, s_q.shadow.dt}, s_d.wdata, s_d.wstrb);
               s_d.shadow.dt = w[9:0]; // [R6]
            end
            `REG_MIN_PULSE:
            begin
               w = merge({16'h0000, s_q.shadow.pd}, s_d.wdata, s_d.wstrb);
               s_d.shadow.pd = w[15:0];
            end
            `REG_SYNC_WIDTH:
            begin
               w = merge({24'h000000, s_q.shadow.sw}, s_d.wdata, s_d.wstrb);
               s_d.shadow.sw = w[7:0]; // [R23]
            end
            `REG_DUTY_A, `REG_DUTY_B, `REG_DUTY_C:
            begin
               for (int i = 0; i < NCH; i++)
               begin
                  if (s_d.awaddr == `REG_DUTY_A + 8'(4 * i))
                  begin
                     w = merge({16'h0000, s_q.shadow.duty[i]}, s_d.wdata, s_d.wstrb);
                     s_d.shadow.duty[i] = w[15:0]; // [R16]
                     s_d.written[i] = 1'b1; // [R19]
                  end
               end
            end
            `REG_MODE_CONTROL:
            begin
               if (s_d.wstrb[0])
               begin
                  s_d.double_mode = s_d.wdata[`MODE_DOUBLE_BIT]; // [R8]
               end
            end
            `REG_SYSTEM_STATUS:
            begin
            end
            `REG_OUTPUT_STEERING:
            begin
               w = merge({23'h0, s_q.steer_sh}, s_d.wdata, s_d.wstrb);
               s_d.steer_sh = w[8:0];
            end
            default:
            begin
               s_d.bresp = `RESP_DECERR;
            end
         endcase
      end
      s_d.awready = !s_d.aw_full && !s_d.bvalid;
      s_d.wready = !s_d.w_full && !s_d.bvalid;

      if (RREADY && s_q.rvalid)
      begin
         s_d.rvalid = 1'b0;
      end
      if (ARVALID && s_q.arready)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = `RESP_OKAY;
         s_d.rdata = 32'h00000000;
         case (ARADDR)
            `REG_HALF_PERIOD: s_d.rdata[15:0] = s_q.shadow.tm;
            `REG_DEAD_TIME: s_d.rdata[9:0] = s_q.shadow.dt;
            `REG_MIN_PULSE: s_d.rdata[15:0] = s_q.shadow.pd;
            `REG_SYNC_WIDTH: s_d.rdata[7:0] = s_q.shadow.sw;
            `REG_DUTY_A: s_d.rdata[15:0] = s_q.shadow.duty[0];
            `REG_DUTY_B: s_d.rdata[15:0] = s_q.shadow.duty[1];
            `REG_DUTY_C: s_d.rdata[15:0] = s_q.shadow.duty[2];
            `REG_MODE_CONTROL: s_d.rdata[`MODE_DOUBLE_BIT] = s_q.double_mode;
            `REG_SYSTEM_STATUS:
            begin
               s_d.rdata[`STAT_HALF_BIT] = s_q.half; // [R13]
               s_d.rdata[`STAT_RUN_BIT] = s_q.run;
            end
            `REG_OUTPUT_STEERING: s_d.rdata[8:0] = s_q.steer_sh;
            default: s_d.rresp = `RESP_DECERR;
         endcase
      end
      s_d.arready = !s_d.rvalid;

      // Period engine: up from zero in the first half, down to one in the second.
      if (!s_q.run)
      begin
         if (&s_d.written)
         begin
            s_d.run = 1'b1; // [R19]
            start = 1'b1;
         end
      end
      else if (!s_q.half)
      begin
         if ({1'b0, s_q.cnt} + 17'h00001 >= {1'b0, s_q.act.tm})
         begin
            mid = 1'b1;
         end
         else
         begin
            s_d.cnt = s_q.cnt + 16'h0001; // [R4] [R22]
         end
      end
      else if (s_q.cnt <= 16'h0001)
      begin
         start = 1'b1; // [R2]
      end
      else
      begin
         s_d.cnt = s_q.cnt - 16'h0001; // [R4] [R22]
      end

      if (start || (mid && s_d.double_mode))
      begin
         // Latest writes, including one in this cycle, enter the new interval.
         s_d.act = s_d.shadow; // [R10] [R12]
         s_d.steer_act = s_d.steer_sh; // [R11]
         s_d.sync = 1'b1; // [R17]
         s_d.sync_left = s_d.shadow.sw; // [R14]
         s_d.irq = 1'b1; // [R21]
      end
      else if (s_q.sync)
      begin
         if (s_q.sync_left == 8'h00)
         begin
            s_d.sync = 1'b0; // [R14]
         end
         else
         begin
            s_d.sync_left = s_q.sync_left - 8'h01;
         end
      end
      if (start)
      begin
         s_d.cnt = 16'h0000;
         s_d.half = 1'b0; // [R13]
      end
      if (mid)
      begin
         s_d.half = 1'b1; // [R13]
         s_d.cnt = s_d.act.tm;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s_q <= '0;
         s_q.shadow.sw <= `SYNC_WIDTH_RST; // [R15]
         s_q.act.sw <= `SYNC_WIDTH_RST;
         s_q.steer_sh <= `STEERING_RST;
         s_q.steer_act <= `STEERING_RST;
         s_q.double_mode <= 1'b0; // [R9]
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign AWREADY = s_q.awready;
   assign WREADY = s_q.wready;
   assign BVALID = s_q.bvalid;
   assign BRESP = s_q.bresp;
   assign ARREADY = s_q.arready;
   assign RVALID = s_q.rvalid;
   assign RDATA = s_q.rdata;
   assign RRESP = s_q.rresp;
   assign PAIRS = s_q.pairs;
   assign STEER = s_q.steer_act;
   assign SYNC = s_q.sync;
   assign IRQ = s_q.irq;

   // Helper: length of the current sync pulse, restarted on each rise.
   logic [8:0] sync_len_q;
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sync_len_q <= 9'h000;
      end
      else
      begin
         sync_len_q <= s_d.irq ? 9'h001 : (s_d.sync ? sync_len_q + 9'h001 : 9'h000);
      end
   end

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);

   // The helper is already cleared in the cycle SYNC falls, so the last high cycle is used.
   sync_width_a: assert property ($fell(SYNC) // [R14]
                                 |-> $past(sync_len_q) == {1'b0, s_q.act.sw} + 9'h001)
      else $error("Sync pulse width differs from width setting plus one.");
   sync_irq_a: assert property (IRQ |-> SYNC && !$past(SYNC) || IRQ && SYNC) // [R21]
      else $error("Interrupt pulse not aligned with sync start.");
   irq_rise_a: assert property ($rose(SYNC) |-> IRQ) // [R21]
      else $error("Sync rise without interrupt pulse.");
   no_overlap_a: assert property ((PAIRS.hi & PAIRS.lo) == 3'b000) // [R5]
      else $error("Both switches of a pair are on together.");
   idle_quiet_a: assert property (!s_q.run |-> PAIRS == '0 && !SYNC) // [R19]
      else $error("Output activity before all timing registers were written.");
   single_sync_a: assert property (IRQ && !s_q.double_mode |-> !s_q.half) // [R10]
      else $error("Single update sync outside period start.");
   mid_sync_a: assert property ($rose(s_q.half) && s_q.double_mode |-> IRQ && s_q.cnt == s_q.act.tm) // [R12]
      else $error("Midpoint of double update without sync and reload.");
   count_up_a: assert property (s_q.run && !s_q.half && $past(s_q.run && !s_q.half) // [R4]
                                |-> s_q.cnt == $past(s_q.cnt) + 16'h0001)
      else $error("Counter did not advance by one in the first half.");
   count_bound_a: assert property (s_q.run |-> s_q.cnt <= s_q.act.tm) // [R22]
      else $error("Counter above half-period count.");
   steer_latch_a: assert property ($changed(STEER) |-> IRQ) // [R11]
      else $error("Steering not latched at sync rise.");

   double_mid_c: cover property (s_q.double_mode && $rose(s_q.half) && IRQ);
   period_start_c: cover property (s_q.run && $fell(s_q.half) && IRQ);
   min_pulse_c: cover property (s_q.run && s_q.act.pd != 16'h0000 && PAIRS.lo[0] && s_q.half);
endmodule

// ==== sim/gate_drive_model.sv ====
`timescale 1ns/10ps
module gate_drive_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire pwm_timing_pkg::pair_out_s pairs,
   input wire logic sync,
   output logic [15:0] gap_q,
   output logic [15:0] hi_q,
   output logic [15:0] lo_q,
   output logic [15:0] width_q,
   output logic [15:0] syncs_q,
   output logic overlap_q
);
   import pwm_timing_pkg::*;
   logic [15:0] cnt_q, hic_q, loc_q, wid_q;
   logic sync_q;
   // Totals cover whole sync-to-sync windows, so the one-cycle lag of the outputs cancels out.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {gap_q, hi_q, lo_q, width_q, syncs_q, cnt_q, hic_q, loc_q, wid_q} <= '0;
         sync_q <= 1'b0;
         overlap_q <= 1'b0;
      end
      else
      begin
         sync_q <= sync;
         wid_q <= sync ? wid_q + 16'h0001 : 16'h0000;
         if (sync_q && !sync)
            width_q <= wid_q;
         // A real bridge would short the link here, so it is remembered for good.
         if (|(pairs.hi & pairs.lo))
            overlap_q <= 1'b1;
         if (sync && !sync_q)
         begin
            gap_q <= cnt_q;
            hi_q <= hic_q;
            lo_q <= loc_q;
            syncs_q <= syncs_q + 16'h0001;
            cnt_q <= 16'h0001;
            hic_q <= {15'h0000, pairs.hi[0]};
            loc_q <= {15'h0000, pairs.lo[0]};
         end
         else
         begin
            cnt_q <= cnt_q + 16'h0001;
            hic_q <= hic_q + {15'h0000, pairs.hi[0]};
            loc_q <= loc_q + {15'h0000, pairs.lo[0]};
         end
      end
   end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
`include "pwm_timing_regs.svh"
module testbench;
   import pwm_timing_pkg::*;
   logic MCLK = 1'b0;
   logic RST_N = 1'b0;
   logic [7:0] AWADDR = 8'h00;
   logic AWVALID = 1'b0;
   logic [31:0] WDATA = 32'h00000000;
   logic [3:0] WSTRB = 4'hf;
   logic WVALID = 1'b0;
   logic BREADY = 1'b0;
   logic [7:0] ARADDR = 8'h00;
   logic ARVALID = 1'b0;
   logic RREADY = 1'b0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SYNC, IRQ, overlap;
   logic [1:0] BRESP, RRESP;
   logic [31:0] RDATA;
   pair_out_s PAIRS;
   logic [8:0] STEER;
   logic [15:0] gap, hi_on, lo_on, width, syncs;
   logic [31:0] st0;
   logic [31:0] st1;
   logic [1:0] bresp_seen = 2'h0;
   logic [15:0] irqs = 16'h0000;
   int failures = 0;
   int checks_done = 0;

   always #50 MCLK = ~MCLK;

   always @(posedge MCLK)
   begin
      if (IRQ)
         irqs <= irqs + 16'h0001;
   end

   three_phase_pwm_timing_core dut (
      .MCLK(MCLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
      .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .PAIRS(PAIRS), .STEER(STEER), .SYNC(SYNC), .IRQ(IRQ)
   );

   gate_drive_model model (
      .clk(MCLK), .rst_n(RST_N), .pairs(PAIRS), .sync(SYNC), .gap_q(gap), .hi_q(hi_on),
      .lo_q(lo_on), .width_q(width), .syncs_q(syncs), .overlap_q(overlap)
   );

   task automatic complete_run();
      if (failures == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic hang(input string nm);
      failures++;
      $display("[FAIL] %s expected answer seen timeout", nm);
      complete_run();
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic got;
      got = 1'b0;
      @(posedge MCLK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      for (n = 0; n < 50 && !got; n++)
      begin
         @(posedge MCLK);
         if (AWREADY)
            AWVALID <= 1'b0;
         if (WREADY)
            WVALID <= 1'b0;
         got = BVALID;
         bresp_seen = BRESP;
      end
      BREADY <= 1'b0;
      if (!got)
         hang("write");
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic got;
      got = 1'b0;
      @(posedge MCLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      for (n = 0; n < 50 && !got; n++)
      begin
         @(posedge MCLK);
         if (ARREADY)
            ARVALID <= 1'b0;
         got = RVALID;
         d = RDATA;
         r = RRESP;
      end
      RREADY <= 1'b0;
      if (!got)
         hang("read");
   endtask

   task automatic read_check(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      chk(nm, exp, d);
      chk("read response", {30'h0, `RESP_OKAY}, {30'h0, r});
   endtask

   task automatic wait_syncs(input int n);
      int k;
      logic [15:0] s;
      s = syncs;
      for (k = 0; k < 3000 && syncs != s + 16'(n); k++)
         @(posedge MCLK);
      if (syncs != s + 16'(n))
         hang("sync pulses");
   endtask

   task automatic t_register_file();
      logic [31:0] d;
      logic [1:0] r;
      read_check("sync width reset", `REG_SYNC_WIDTH, 32'h00000027);
      read_check("mode reset", `REG_MODE_CONTROL, 32'h00000000);
      axi_write(`REG_HALF_PERIOD, 32'hffffffff);
      read_check("half period max", `REG_HALF_PERIOD, 32'h0000ffff);
      axi_write(`REG_DEAD_TIME, 32'hffffffff);
      read_check("dead time width", `REG_DEAD_TIME, 32'h000003ff);
      axi_write(`REG_DUTY_A, 32'hffffffff);
      read_check("duty width", `REG_DUTY_A, 32'h0000ffff);
      axi_read(8'h40, d, r);
      chk("unmapped response", {30'h0, `RESP_DECERR}, {30'h0, r});
      axi_write(8'h40, 32'h00000000);
      chk("unmapped write response", {30'h0, `RESP_DECERR}, {30'h0, bresp_seen});
      axi_write(`REG_SYSTEM_STATUS, 32'hffffffff);
      chk("status write response", {30'h0, `RESP_OKAY}, {30'h0, bresp_seen});
      read_check("status after write", `REG_SYSTEM_STATUS, 32'h00000000);
      axi_write(`REG_DEAD_TIME, 32'h00000000);
      axi_write(`REG_HALF_PERIOD, 32'h00000032);
      axi_write(`REG_DUTY_A, 32'h00000004);
   endtask

   task automatic t_held_off();
      repeat (20) @(posedge MCLK);
      chk("sync before start", 32'h0, {16'h0, syncs});
      chk("outputs before start", 32'h0, {26'h0, PAIRS});
      read_check("status before start", `REG_SYSTEM_STATUS, 32'h00000000);
   endtask

   task automatic t_single_update();
      axi_write(`REG_DUTY_B, 32'h00000004);
      axi_write(`REG_DUTY_C, 32'h00000004);
      wait_syncs(3);
      chk("single period", 32'd100, {16'h0, gap});
      chk("default sync width", 32'd40, {16'h0, width});
      chk("high on time", 32'd8, {16'h0, hi_on});
      chk("low on time", 32'd92, {16'h0, lo_on});
   endtask

   task automatic t_steering();
      wait_syncs(1);
      axi_write(`REG_OUTPUT_STEERING, 32'h000001a5);
      chk("steering before sync", 32'h0, {23'h0, STEER});
      wait_syncs(1);
      chk("steering after sync", 32'h1a5, {23'h0, STEER});
   endtask

   task automatic t_dead_time();
      axi_write(`REG_SYNC_WIDTH, 32'h00000002);
      axi_write(`REG_HALF_PERIOD, 32'h00000008);
      axi_write(`REG_DEAD_TIME, 32'h00000001);
      wait_syncs(3);
      chk("short period", 32'd16, {16'h0, gap});
      chk("sync width", 32'd3, {16'h0, width});
      chk("high minus dead time", 32'd6, {16'h0, hi_on});
      chk("low minus dead time", 32'd6, {16'h0, lo_on});
      chk("no overlap", 32'h0, {31'h0, overlap});
   endtask

   task automatic t_min_pulse();
      axi_write(`REG_MIN_PULSE, 32'h00000004);
      wait_syncs(3);
      chk("short high dropped", 32'd0, {16'h0, hi_on});
      chk("low held on", 32'd16, {16'h0, lo_on});
      axi_write(`REG_MIN_PULSE, 32'h00000000);
   endtask

   task automatic t_double_update();
      logic [1:0] r;
      axi_write(`REG_MODE_CONTROL, 32'h00000040);
      read_check("mode set", `REG_MODE_CONTROL, 32'h00000040);
      wait_syncs(3);
      chk("double sync spacing", 32'd8, {16'h0, gap});
      wait_syncs(1);
      axi_read(`REG_SYSTEM_STATUS, st0, r);
      wait_syncs(1);
      axi_read(`REG_SYSTEM_STATUS, st1, r);
      chk("half bit alternates", 32'h1, {31'h0, st0[3] ^ st1[3]});
      chk("interrupt per sync", {16'h0, syncs}, {16'h0, irqs});
   endtask

   initial
   begin
      repeat (4) @(posedge MCLK);
      RST_N <= 1'b1;
      t_register_file();
      t_held_off();
      t_single_update();
      t_steering();
      t_dead_time();
      t_min_pulse();
      t_double_update();
      complete_run();
   end
endmodule
